// file: hw/dtm_map.vh
// Register map, field positions and divider taps of the dual timer
`ifndef DTM_MAP_VH
`define DTM_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DTM_ADDR_MODE_A   16'hff70
`define DTM_ADDR_CLK_A    16'hff71
`define DTM_ADDR_MODE_B   16'hff74
`define DTM_ADDR_CLK_B    16'hff75
`define DTM_ADDR_CNT_A    16'hff72
`define DTM_ADDR_CMP_A    16'hff73
`define DTM_ADDR_CNT_B    16'hff76
`define DTM_ADDR_CMP_B    16'hff77

// ----------------------------------------------------------------------
// Mode register fields and reset values
// ----------------------------------------------------------------------
`define DTM_BIT_OE        3'd0
`define DTM_BIT_INV       3'd1
`define DTM_BIT_LVR       3'd2
`define DTM_BIT_LVS       3'd3
`define DTM_BIT_CASC      3'd4
`define DTM_BIT_PWM       3'd6
`define DTM_BIT_RUN       3'd7
`define DTM_MODE_A_WMASK  8'hc3
`define DTM_MODE_B_WMASK  8'hd3
`define DTM_CLK_WMASK     8'h07
`define DTM_RST_BYTE      8'h00

// ----------------------------------------------------------------------
// Clock select codes and prescaler taps (bit index into divider)
// ----------------------------------------------------------------------
`define DTM_SEL_FALL      3'h0
`define DTM_SEL_RISE      3'h1
`define DTM_SEL_SYS       3'h2
`define DTM_TAP_D2        4'd0
`define DTM_TAP_D8        4'd2
`define DTM_TAP_D32       4'd4
`define DTM_TAP_D128      4'd6
`define DTM_TAP_D256      4'd7
`define DTM_TAP_D512      4'd8
`define DTM_TAP_D4096     4'd11
`define DTM_PRESCALE_W    12

`endif

// file: hw/dtm_prescaler.v
// Free-running prescaler producing one-cycle divide ticks
`timescale 1ns/10ps
`include "dtm_map.vh"

module dtm_prescaler (
  // Clock and reset
  input  wire                       clk,
  input  wire                       reset_n,
  // Tick per tap: bit k pulses once every 2^(k+1) cycles
  output reg  [`DTM_PRESCALE_W-1:0] tick_ff
);

  reg  [`DTM_PRESCALE_W-1:0] div_ff;
  wire [`DTM_PRESCALE_W-1:0] nxt_div;

  assign nxt_div = div_ff + {{(`DTM_PRESCALE_W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (!reset_n) begin
      div_ff  <= {`DTM_PRESCALE_W{1'b0}};
      tick_ff <= {`DTM_PRESCALE_W{1'b0}};
    end else begin
      div_ff  <= nxt_div;
      // Ticks where a bit falls: exactly one pulse per period
      tick_ff <= div_ff & ~nxt_div;
    end
  end

endmodule // dtm_prescaler

// file: hw/dtm_edge_sync.v
// Three-stage synchroniser with edge detection for an event input
`timescale 1ns/10ps

module dtm_edge_sync (
  // Clock and reset
  input  wire clk,
  input  wire reset_n,
  // Asynchronous pin
  input  wire pin_in,
  // Synchronous edge pulses
  output wire rise,
  output wire fall
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg lvl_ff;

  always @(posedge clk) begin
    if (!reset_n) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Level changes only when stages two and three agree
      if (s2_ff == s3_ff)
        lvl_ff <= s3_ff;
    end
  end

  assign rise = (s2_ff == s3_ff) &  s3_ff & ~lvl_ff;
  assign fall = (s2_ff == s3_ff) & ~s3_ff &  lvl_ff;

endmodule // dtm_edge_sync

// file: hw/dtm_timer.v
// Dual 8-bit timer/event counter with cascade, PWM and output control
`timescale 1ns/10ps
`include "dtm_map.vh"

module dtm_timer (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Register port
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_bit_wr,
  input  wire [2:0]  reg_bit_sel,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_ff,
  // Event inputs
  input  wire        event_input_a,
  input  wire        event_input_b,
  // Timer outputs and their enables
  output wire        timer_output_a,
  output wire        output_enable_a,
  output wire        timer_output_b,
  output wire        output_enable_b,
  // Match interrupts
  output reg         match_irq_a_ff,
  output reg         match_irq_b_ff
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [7:0] mode_a_ff;
  reg  [7:0] mode_b_ff;
  reg  [2:0] clk_a_ff;
  reg  [2:0] clk_b_ff;
  reg  [7:0] compare_a_ff;
  reg  [7:0] compare_b_ff;
  reg  [7:0] counter_a_ff;
  reg  [7:0] counter_b_ff;
  reg        ff_a_ff;
  reg        ff_b_ff;

  wire [`DTM_PRESCALE_W-1:0] tick;
  wire       rise_a;
  wire       fall_a;
  wire       rise_b;
  wire       fall_b;

  dtm_prescaler u_pre (
    .clk     (clk),
    .reset_n (reset_n),
    .tick_ff (tick)
  );

  dtm_edge_sync u_sync_a (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (event_input_a),
    .rise    (rise_a),
    .fall    (fall_a)
  );

  dtm_edge_sync u_sync_b (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (event_input_b),
    .rise    (rise_b),
    .fall    (fall_b)
  );

  // --------------------------------------------------------------------
  // Count clock selection
  // --------------------------------------------------------------------
  function count_tick;
    input [2:0]                  sel;
    input                        is_b;
    input                        rs;
    input                        fl;
    input [`DTM_PRESCALE_W-1:0]  tk;
    begin
      case (sel)
        `DTM_SEL_FALL: count_tick = fl;
        `DTM_SEL_RISE: count_tick = rs;
        `DTM_SEL_SYS:  count_tick = 1'b1;
        3'h3:    count_tick = tk[`DTM_TAP_D2];
        3'h4:    count_tick = tk[`DTM_TAP_D8];
        3'h5:    count_tick = tk[`DTM_TAP_D32];
        3'h6:    count_tick = is_b ? tk[`DTM_TAP_D256]
                                   : tk[`DTM_TAP_D128];
        default: count_tick = is_b ? tk[`DTM_TAP_D512]
                                   : tk[`DTM_TAP_D4096];
      endcase
    end
  endfunction

  wire tick_a = count_tick(clk_a_ff, 1'b0, rise_a, fall_a, tick);
  wire tick_b = count_tick(clk_b_ff, 1'b1, rise_b, fall_b, tick);

  // --------------------------------------------------------------------
  // Mode fields
  // --------------------------------------------------------------------
  wire run_a          = mode_a_ff[`DTM_BIT_RUN];
  wire run_b          = mode_b_ff[`DTM_BIT_RUN];
  wire pwm_select_a   = mode_a_ff[`DTM_BIT_PWM];
  wire pwm_select_b   = mode_b_ff[`DTM_BIT_PWM];
  wire cascade_select = mode_b_ff[`DTM_BIT_CASC];
  wire polarity_invert_a = mode_a_ff[`DTM_BIT_INV];
  wire polarity_invert_b = mode_b_ff[`DTM_BIT_INV];

  wire [15:0] casc_cnt = {counter_b_ff, counter_a_ff};
  wire [15:0] casc_cmp = {compare_b_ff, compare_a_ff};

  // Match conditions; cascade compares the full 16 bits
  wire match_a = run_a & tick_a & (cascade_select ?
                 (casc_cnt == casc_cmp) :
                 (counter_a_ff == compare_a_ff));
  wire match_b = cascade_select ? match_a :
                 (run_b & tick_b & (counter_b_ff == compare_b_ff));

  // Register write strobes
  wire wr_mode_a = (reg_wr | reg_bit_wr) &
                   (reg_addr == `DTM_ADDR_MODE_A);
  wire wr_mode_b = (reg_wr | reg_bit_wr) &
                   (reg_addr == `DTM_ADDR_MODE_B);
  wire wr_clk_a  = reg_wr & (reg_addr == `DTM_ADDR_CLK_A);
  wire wr_clk_b  = reg_wr & (reg_addr == `DTM_ADDR_CLK_B);

  // Merge a bit or byte write into a mode byte
  function [7:0] merge_mode;
    input [7:0] old;
    input       bit_wr;
    input [2:0] sel;
    input [7:0] wd;
    input [7:0] mask;
    reg   [7:0] nv;
    begin
      nv = old;
      if (bit_wr)
        nv[sel] = wd[0];
      else
        nv = wd;
      merge_mode = nv & mask;
    end
  endfunction

  wire [7:0] nxt_mode_a = merge_mode(mode_a_ff, reg_bit_wr, reg_bit_sel,
                                     reg_wdata, `DTM_MODE_A_WMASK);
  wire [7:0] nxt_mode_b = merge_mode(mode_b_ff, reg_bit_wr, reg_bit_sel,
                                     reg_wdata, `DTM_MODE_B_WMASK);

  // Effective level bits of a write (stored never, so they read zero)
  function [1:0] level_bits;
    input       bit_wr;
    input [2:0] sel;
    input [7:0] wd;
    begin
      if (bit_wr)
        level_bits = {(sel == `DTM_BIT_LVS) & wd[0],
                      (sel == `DTM_BIT_LVR) & wd[0]};
      else
        level_bits = {wd[`DTM_BIT_LVS], wd[`DTM_BIT_LVR]};
    end
  endfunction

  wire [1:0] lv_a = level_bits(reg_bit_wr, reg_bit_sel, reg_wdata);
  wire [1:0] lv_b = lv_a;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      mode_a_ff <= `DTM_RST_BYTE;
      mode_b_ff <= `DTM_RST_BYTE;
      clk_a_ff  <= 3'h0;
      clk_b_ff  <= 3'h0;
      compare_a_ff <= `DTM_RST_BYTE;
      compare_b_ff <= `DTM_RST_BYTE;
    end else begin
      if (wr_mode_a)
        mode_a_ff <= nxt_mode_a;
      if (wr_mode_b)
        mode_b_ff <= nxt_mode_b;
      if (wr_clk_a)
        clk_a_ff <= reg_wdata[2:0];
      if (wr_clk_b)
        clk_b_ff <= reg_wdata[2:0];
      if (reg_wr && reg_addr == `DTM_ADDR_CMP_A)
        compare_a_ff <= reg_wdata;
      if (reg_wr && reg_addr == `DTM_ADDR_CMP_B)
        compare_b_ff <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      counter_a_ff <= `DTM_RST_BYTE;
      counter_b_ff <= `DTM_RST_BYTE;
    end else if (cascade_select) begin
      if (!run_a) begin
        counter_a_ff <= `DTM_RST_BYTE;
        counter_b_ff <= `DTM_RST_BYTE;
      end else if (tick_a) begin
        if (match_a && !pwm_select_a) begin
          counter_a_ff <= `DTM_RST_BYTE;
          counter_b_ff <= `DTM_RST_BYTE;
        end else begin
          {counter_b_ff, counter_a_ff} <= casc_cnt + 16'h0001;
        end
      end
    end else begin
      if (!run_a)
        counter_a_ff <= `DTM_RST_BYTE;
      else if (tick_a)
        counter_a_ff <= (match_a && !pwm_select_a) ?
                        `DTM_RST_BYTE : counter_a_ff + 8'h01;
      if (!run_b)
        counter_b_ff <= `DTM_RST_BYTE;
      else if (tick_b)
        counter_b_ff <= (match_b && !pwm_select_b) ?
                        `DTM_RST_BYTE : counter_b_ff + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Output flip-flops and interrupts
  // --------------------------------------------------------------------
  // PWM: active from counter overflow until compare match
  function nxt_out;
    input       cur;
    input       lv_wr;
    input [1:0] lv;
    input       pwm;
    input       inv;
    input       run;
    input       tk;
    input       match;
    input [7:0] cnt;
    begin
      nxt_out = cur;
      if (lv_wr && lv == 2'b01)
        nxt_out = 1'b0;
      else if (lv_wr && lv == 2'b10)
        nxt_out = 1'b1;
      else if (run && pwm) begin
        if (match)
          nxt_out = 1'b0;
        else if (tk && cnt == 8'hff)
          nxt_out = 1'b1;
      end else if (run && inv && match)
        nxt_out = ~cur;
    end
  endfunction

  always @(posedge clk) begin
    if (!reset_n) begin
      ff_a_ff        <= 1'b0;
      ff_b_ff        <= 1'b0;
      match_irq_a_ff <= 1'b0;
      match_irq_b_ff <= 1'b0;
    end else begin
      ff_a_ff <= nxt_out(ff_a_ff, wr_mode_a, lv_a, pwm_select_a,
                         polarity_invert_a, run_a, tick_a, match_a,
                         counter_a_ff);
      ff_b_ff <= nxt_out(ff_b_ff, wr_mode_b, lv_b, pwm_select_b,
                         polarity_invert_b, run_b | cascade_select,
                         tick_b, match_b, counter_b_ff);
      match_irq_a_ff <= match_a;
      match_irq_b_ff <= match_b;
    end
  end

  // Active-low select only applies in PWM mode
  assign timer_output_a  = ff_a_ff ^
                           (pwm_select_a & polarity_invert_a);
  assign timer_output_b  = ff_b_ff ^ (pwm_select_b & polarity_invert_b);
  assign output_enable_a = mode_a_ff[`DTM_BIT_OE];
  assign output_enable_b = mode_b_ff[`DTM_BIT_OE];

  // --------------------------------------------------------------------
  // Read-back, byte wide; unmapped addresses return zero
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n)
      reg_rdata_ff <= `DTM_RST_BYTE;
    else if (reg_rd) begin
      if (reg_addr == `DTM_ADDR_MODE_A)
        reg_rdata_ff <= mode_a_ff;
      else if (reg_addr == `DTM_ADDR_MODE_B)
        reg_rdata_ff <= mode_b_ff;
      else if (reg_addr == `DTM_ADDR_CLK_A)
        reg_rdata_ff <= {5'h00, clk_a_ff};
      else if (reg_addr == `DTM_ADDR_CLK_B)
        reg_rdata_ff <= {5'h00, clk_b_ff};
      else if (reg_addr == `DTM_ADDR_CNT_A)
        reg_rdata_ff <= counter_a_ff;
      else if (reg_addr == `DTM_ADDR_CNT_B)
        reg_rdata_ff <= counter_b_ff;
      else if (reg_addr == `DTM_ADDR_CMP_A)
        reg_rdata_ff <= compare_a_ff;
      else if (reg_addr == `DTM_ADDR_CMP_B)
        reg_rdata_ff <= compare_b_ff;
      else
        reg_rdata_ff <= `DTM_RST_BYTE;
    end
  end

endmodule // dtm_timer

// file: test/dtm_timer_assertions.sv
// Concurrent checks on the dual timer register port and pins
`timescale 1ns/10ps
`include "dtm_map.vh"

module dtm_timer_assertions (
  // Clock and reset
  input wire        clk,
  input wire        reset_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_bit_wr,
  input wire [2:0]  reg_bit_sel,
  input wire [7:0]  reg_wdata,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_ff,
  // Pins and interrupts
  input wire        timer_output_a,
  input wire        output_enable_a,
  input wire        output_enable_b,
  input wire        match_irq_a_ff,
  input wire        match_irq_b_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ----
  // Steps of multi-cycle accesses
  // ----
  sequence s_stop_a;
    reg_wr && reg_addr == `DTM_ADDR_MODE_A && !reg_wdata[7];
  endsequence
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_quiet;
    !reg_wr && !reg_bit_wr;
  endsequence

  chk_reset_quiet: assert property (
    $rose(reset_n) |-> !output_enable_a && !output_enable_b &&
      !match_irq_a_ff && !match_irq_b_ff && reg_rdata_ff == 8'h00)
    else $error("outputs not idle after reset");
  chk_oe_a_byte: assert property (
    reg_wr && reg_addr == `DTM_ADDR_MODE_A |=>
      output_enable_a == $past(reg_wdata[0]))
    else $error("output enable a wrong");
  chk_oe_b_bit: assert property (
    reg_bit_wr && reg_addr == `DTM_ADDR_MODE_B && reg_bit_sel == 3'h0
      |=> output_enable_b == $past(reg_wdata[0]))
    else $error("bit write to enable b lost");
  chk_level_set: assert property (
    reg_wr && reg_addr == `DTM_ADDR_MODE_A &&
      (reg_wdata & 8'h4e) == 8'h08 |=> timer_output_a)
    else $error("level set ignored");
  chk_level_clear: assert property (
    reg_wr && reg_addr == `DTM_ADDR_MODE_A &&
      (reg_wdata & 8'h4e) == 8'h04 |=> !timer_output_a)
    else $error("level reset ignored");
  chk_level_reads_zero: assert property (
    reg_rd && (reg_addr == `DTM_ADDR_MODE_A ||
      reg_addr == `DTM_ADDR_MODE_B) |=> reg_rdata_ff[3:2] == 2'h0)
    else $error("level bits read back set");
  chk_clk_sel_mask: assert property (
    reg_rd && (reg_addr == `DTM_ADDR_CLK_A ||
      reg_addr == `DTM_ADDR_CLK_B) |=> reg_rdata_ff[7:3] == 5'h00)
    else $error("clock select upper bits set");
  chk_stop_clears: assert property (
    s_stop_a ##2 s_rd(`DTM_ADDR_CNT_A) |=> reg_rdata_ff == 8'h00)
    else $error("stopped counter not zero");
  chk_mode_b_mask: assert property (
    reg_wr && reg_addr == `DTM_ADDR_MODE_B ##1 s_quiet
      ##1 s_rd(`DTM_ADDR_MODE_B)
      |=> reg_rdata_ff == ($past(reg_wdata, 3) & 8'hd3))
    else $error("mode b readback wrong");
endmodule // dtm_timer_assertions

bind dtm_timer dtm_timer_assertions u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .timer_output_a(timer_output_a), .output_enable_a(output_enable_a),
  .output_enable_b(output_enable_b), .match_irq_a_ff(match_irq_a_ff),
  .match_irq_b_ff(match_irq_b_ff)
);

// file: test/dtm_pulse_src.sv
// External pulse source driving both event input pins
`timescale 1ns/10ps

module dtm_pulse_src (
  // Clock
  input  wire  clk,
  // Event pins
  output logic event_input_a,
  output logic event_input_b
);
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
  end

  // Pins rest low; h cycles high then h low, long enough to synchronise
  task automatic burst(input logic b, input int n, input int h);
    repeat (n) begin
      if (b) event_input_b = 1'b1;
      else event_input_a = 1'b1;
      repeat (h) @(posedge clk);
      #1;
      event_input_a = 1'b0;
      event_input_b = 1'b0;
      repeat (h) @(posedge clk);
      #1;
    end
  endtask
endmodule // dtm_pulse_src

// file: test/dtm_timer_test.sv
// Self-checking bench for the dual timer through its register port
`timescale 1ns/10ps
`include "dtm_map.vh"

module dtm_timer_test;
  logic        clk, reset_n, reg_wr, reg_bit_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [2:0]  reg_bit_sel;
  logic [7:0]  reg_wdata, reg_rdata_ff, v;
  logic        ev_a, ev_b, to_a, oe_a, to_b, oe_b, irq_a, irq_b;
  int          error_cnt, checks_done, cyc, n, hi;
  int          da[8] = '{0, 0, 1, 2, 8, 32, 128, 4096};
  int          db[8] = '{0, 0, 1, 2, 8, 32, 256, 512};
  logic [15:0] ra[6] = '{16'hff70, 16'hff71, 16'hff74, 16'hff75,
                         16'hff72, 16'hff76};

  dtm_timer u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .event_input_a(ev_a), .event_input_b(ev_b), .timer_output_a(to_a),
    .output_enable_a(oe_a), .timer_output_b(to_b),
    .output_enable_b(oe_b), .match_irq_a_ff(irq_a), .match_irq_b_ff(irq_b)
  );
  dtm_pulse_src u_src (
    .clk(clk), .event_input_a(ev_a), .event_input_b(ev_b)
  );

  always #2.5 clk = ~clk;

  // ----
  // Access tasks; each leaves one idle cycle so strobes never double up
  // ----
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic bwr(input logic [15:0] a, input logic [2:0] s,
                     input logic b);
    reg_addr = a;
    reg_bit_sel = s;
    reg_wdata = {7'h00, b};
    reg_bit_wr = 1'b1;
    @(posedge clk);
    #1 reg_bit_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 d = reg_rdata_ff;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wirq(input logic b);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((b ? irq_b : irq_a) !== 1'b1 && n < 9000);
  endtask
  // Second interval only: the prescaler phase skews the first one
  task automatic meas(input logic b, input logic [2:0] c, input int d);
    logic [15:0] base;
    base = b ? `DTM_ADDR_MODE_B : `DTM_ADDR_MODE_A;
    wr(base + 16'h0001, {5'h00, c});
    wr(base + 16'h0003, 8'h01);
    wr(base, 8'h80);
    wirq(b);
    wirq(b);
    chk(n, 2 * d);
    wr(base, 8'h00);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("ERROR %0t: run did not finish", $time);
      summarize();
    end
  end

  initial begin
    {clk, reset_n, reg_wr, reg_bit_wr, reg_rd} = 5'h00;
    {reg_addr, reg_bit_sel, reg_wdata} = 27'h0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, 16'h0000);
    end
    // ----
    // Writable mode and clock bits read back, read-only counter
    // ----
    wr(16'hff71, 8'h07);
    rd(16'hff71, v);
    chk(v, 16'h0007);
    wr(16'hff74, 8'h53);
    rd(16'hff74, v);
    chk(v, 16'h0053);
    wr(16'hff70, 8'h43);
    rd(16'hff70, v);
    chk(v, 16'h0043);
    wr(16'hff70, 8'h00);
    wr(16'hff74, 8'h00);
    wr(16'hff72, 8'h55);
    rd(16'hff72, v);
    chk(v, 16'h0000);
    for (int c = 2; c < 8; c++) begin
      meas(1'b0, c[2:0], da[c]);
      meas(1'b1, c[2:0], db[c]);
    end
    // ----
    // Pin edges; timer output left off meanwhile
    // ----
    wr(16'hff71, 8'h00);
    wr(16'hff73, 8'hff);
    wr(16'hff70, 8'h80);
    u_src.burst(1'b0, 5, 4);
    rd(16'hff72, v);
    chk(v, 16'h0005);
    wr(16'hff75, 8'h01);
    wr(16'hff77, 8'hff);
    wr(16'hff74, 8'h80);
    u_src.burst(1'b1, 3, 4);
    rd(16'hff76, v);
    chk(v, 16'h0003);
    bwr(16'hff70, 3'h7, 1'b0);
    bwr(16'hff74, 3'h7, 1'b0);
    bwr(16'hff74, 3'h0, 1'b1);
    chk(oe_b, 16'h0001);
    bwr(16'hff74, 3'h0, 1'b0);
    // Timer B output flip-flop: byte set, then bit-wise clear
    wr(16'hff74, 8'h09);
    chk(to_b, 16'h0001);
    bwr(16'hff74, 3'h2, 1'b1);
    chk(to_b, 16'h0000);
    wr(16'hff74, 8'h00);
    // ----
    // Level bits and toggle on match
    // ----
    wr(16'hff71, 8'h02);
    wr(16'hff73, 8'h03);
    wr(16'hff70, 8'h09);
    chk(to_a, 16'h0001);
    chk(oe_a, 16'h0001);
    wr(16'hff70, 8'h05);
    chk(to_a, 16'h0000);
    wr(16'hff70, 8'h83);
    wirq(1'b0);
    @(posedge clk);
    #1 chk(to_a, 16'h0001);
    wirq(1'b0);
    @(posedge clk);
    #1 chk(to_a, 16'h0000);
    rd(16'hff70, v);
    chk(v, 16'h0083);
    wr(16'hff70, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(16'hff73, 8'h40);
      wr(16'hff70, i ? 8'hc3 : 8'hc1);
      repeat (260) @(posedge clk);
      hi = 0;
      repeat (256) begin
        @(posedge clk);
        #1 hi += to_a;
      end
      if (i) hi = 256 - hi;
      chk(hi inside {64, 65}, 16'h0001);
      wr(16'hff70, 8'h00);
    end
    // ----
    // Cascade
    // ----
    wr(16'hff74, 8'h10);
    wr(16'hff73, 8'hff);
    wr(16'hff77, 8'hff);
    wr(16'hff70, 8'h80);
    repeat (300) @(posedge clk);
    #1 rd(16'hff76, v);
    chk(v, 16'h0001);
    wr(16'hff70, 8'h00);
    rd(16'hff72, v);
    chk(v, 16'h0000);
    rd(16'hff76, v);
    chk(v, 16'h0000);
    summarize();
  end
endmodule // dtm_timer_test
